// ### verilog/cgm_regs.sv
// codec gain, mute, attenuation and short status registers with bit clock and frame sync
//
// Contract
// - line gain field bits 7:6, 00 reserved
// - bit 5 set silences line input
// - mic gain field bits 4:3
// - bit 2 set removes microphone from mixer
// - bit 1 set mutes handset input
// - bit 0 picks recursive or FIR filter
// - receive gain bits 6:2, 1.5 dB steps
// - transmit gain bits 6:2, same coding
// - adc bit 1 zero mutes line out
// - adc bit 0 zero mutes handset out
// - dac bit 1 gates left speaker
// - dac bit 0 gates right speaker
// - status bit 7 shows left speaker short
// - status bit 6 shows right speaker short
// - status bit 5 line short, 4:0 zero
// - line attenuation field bits 3:2
// - speaker attenuation field bits 1:0
// - reset values 47, 5c, 5c, 00, 00
// - low reset restores every register
// - reset also wakes device from sleep
// - bit clock driven in master, input in slave
// - frame sync output marks each frame
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "cgm_consts.svh"
module cgm_regs #(
   parameter int BCLK_DIV = 2,
   parameter int FRAME_BITS = 32
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // analog side
   input wire logic [2:0] short_flags_i,
   output cgm_pkg::cgm_in_path_type in_path_o,
   output cgm_pkg::cgm_out_path_type out_path_o,
   // serial link pins
   input wire logic master_mode_i,
   input wire logic sleep_req_i,
   input wire logic bclk_i,
   output logic bclk_o,
   output logic bclk_oe_o,
   output logic frame_sync_out_o,
   output logic sleep_o
);
   import cgm_pkg::*;

   // elaboration check on counts that fit the 8-bit counters
   // the divider and the bit counter are eight bits wide, so larger counts would wrap silently
   // a frame of one bit would keep frame sync high for good, so two bits is the floor
   if (BCLK_DIV < 1 || BCLK_DIV > 255 || FRAME_BITS < 2 || FRAME_BITS > 256)
   begin : g_bad_param
      $error("cgm_regs: BCLK_DIV or FRAME_BITS out of range");
   end

   localparam logic [7:0] DIV_LAST = 8'(BCLK_DIV - 1);
   localparam logic [7:0] BIT_LAST = 8'(FRAME_BITS - 1);

   cgm_state_type st_ff; // registered state
   cgm_state_type nxt_st; // next state
   logic req; // bus request present
   logic wr_take; // write takes effect this edge
   logic [5:0] idx; // register index
   logic bit_rise; // one bit clock rising edge
   logic [7:0] wbyte; // low write byte

   assign req = wb_cyc_i & wb_stb_i;
   assign idx = wb_adr_i[7:2];
   assign wbyte = wb_dat_i[7:0];
   // write lands at the edge where the master sees ack
   assign wr_take = req & wb_we_i & st_ff.ack & wb_sel_i[0];

   // next-state logic
   // the bus side answers every request in one cycle: ack rises the edge after the request is seen
   // and the write lands on the edge where the master samples that ack, so a master that drops
   // its request early loses the write rather than corrupting a neighbouring register
   // read data is captured together with the ack and then held, so a slow master still sees it
   // the link side runs from one divider in master mode or from edges of the host clock in slave
   // mode; both feed the same bit counter, so frame sync rises once every FRAME_BITS bit clocks in either mode
   // sleep freezes the link only; registers stay readable and writable while asleep
   always_comb
   begin
      nxt_st = st_ff;
      bit_rise = 1'b0;
      // single-cycle ack, dropped the cycle after
      nxt_st.ack = req & ~st_ff.ack;
      // read data latched with the ack
      if (req & ~st_ff.ack)
      begin
         unique case (idx)
            `CGM_IDX_RX_GAIN: nxt_st.rdat = st_ff.rx_gain;
            `CGM_IDX_ADC_VOL: nxt_st.rdat = st_ff.adc_vol;
            `CGM_IDX_DAC_VOL: nxt_st.rdat = st_ff.dac_vol;
            `CGM_IDX_STATUS: nxt_st.rdat = st_ff.status;
            `CGM_IDX_ATTEN: nxt_st.rdat = st_ff.atten;
            default: nxt_st.rdat = 8'h00; // unmapped reads zero
         endcase
      end
      // register writes, reserved bits masked
      if (wr_take)
      begin
         unique case (idx)
            `CGM_IDX_RX_GAIN: nxt_st.rx_gain = wbyte & `CGM_WMASK_RX_GAIN;
            `CGM_IDX_ADC_VOL: nxt_st.adc_vol = wbyte & `CGM_WMASK_VOL;
            `CGM_IDX_DAC_VOL: nxt_st.dac_vol = wbyte & `CGM_WMASK_VOL;
            `CGM_IDX_ATTEN: nxt_st.atten = wbyte & `CGM_WMASK_ATTEN;
            default: nxt_st.rdat = nxt_st.rdat; // status and unmapped ignore writes
         endcase
      end
      // live short-circuit flags, low bits zero
      nxt_st.status = {short_flags_i, 5'h00};
      // sleep entered on request, left only by reset
      if (sleep_req_i)
      begin
         nxt_st.pwr = PWR_SLEEP;
      end
      // bit clock direction follows the mode
      nxt_st.bclk_oe = master_mode_i;
      nxt_st.bclk_prev = bclk_i;
      if (st_ff.pwr == PWR_SLEEP)
      begin
         // link stands still while asleep
         nxt_st.bclk = 1'b0;
         nxt_st.div_cnt = 8'h00;
         nxt_st.frame_sync_out = 1'b0;
      end
      else if (master_mode_i)
      begin
         // divided bit clock driven out
         if (st_ff.div_cnt == DIV_LAST)
         begin
            nxt_st.div_cnt = 8'h00;
            nxt_st.bclk = ~st_ff.bclk;
            bit_rise = ~st_ff.bclk;
         end
         else
         begin
            nxt_st.div_cnt = st_ff.div_cnt + 8'h01;
         end
      end
      else
      begin
         // slave: count edges of the incoming clock
         nxt_st.bclk = 1'b0;
         nxt_st.div_cnt = 8'h00;
         bit_rise = bclk_i & ~st_ff.bclk_prev;
      end
      // frame sync high for the first bit of each frame
      if (bit_rise)
      begin
         nxt_st.bit_cnt = (st_ff.bit_cnt == BIT_LAST) ? 8'h00 : st_ff.bit_cnt + 8'h01;
         nxt_st.frame_sync_out = (nxt_st.bit_cnt == 8'h00);
      end
   end

   // state register, reset loads the documented values
   // the reset branch loads constants only; the bit counter starts on its last value so that
   // the first bit clock rise after reset opens a frame with frame sync high
   // reset is the only way out of sleep, so the power state is cleared here and nowhere else
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_ff <= '0;
         st_ff.rx_gain <= `CGM_RST_RX_GAIN;
         st_ff.adc_vol <= `CGM_RST_VOL;
         st_ff.dac_vol <= `CGM_RST_VOL;
         st_ff.status <= `CGM_RST_STATUS;
         st_ff.atten <= `CGM_RST_ATTEN;
         st_ff.pwr <= PWR_RUN;
         st_ff.bit_cnt <= BIT_LAST;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // bus outputs
   assign wb_ack_o = st_ff.ack;
   assign wb_dat_o = {24'h000000, st_ff.rdat};

   // input path fields
   assign in_path_o.line_in_gain_sel = st_ff.rx_gain[`CGM_LIG_LSB +: 2];
   assign in_path_o.line_in_silence = st_ff.rx_gain[`CGM_LIM_BIT];
   assign in_path_o.microphone_gain_sel = st_ff.rx_gain[`CGM_MCG_LSB +: 2];
   assign in_path_o.microphone_silence = st_ff.rx_gain[`CGM_MCM_BIT];
   assign in_path_o.handset_in_silence = st_ff.rx_gain[`CGM_HIM_BIT];
   assign in_path_o.recursive_filter_select = st_ff.rx_gain[`CGM_IIR_BIT];

   // output path fields
   assign out_path_o.receive_pga_gain = st_ff.adc_vol[`CGM_PGA_LSB +: 5];
   assign out_path_o.transmit_pga_gain = st_ff.dac_vol[`CGM_PGA_LSB +: 5];
   assign out_path_o.line_out_enable = st_ff.adc_vol[`CGM_EN_HI_BIT];
   assign out_path_o.handset_out_enable = st_ff.adc_vol[`CGM_EN_LO_BIT];
   assign out_path_o.left_speaker_enable = st_ff.dac_vol[`CGM_EN_HI_BIT];
   assign out_path_o.right_speaker_enable = st_ff.dac_vol[`CGM_EN_LO_BIT];
   assign out_path_o.line_out_atten = st_ff.atten[`CGM_LOT_LSB +: 2];
   assign out_path_o.speaker_out_atten = st_ff.atten[`CGM_SOT_LSB +: 2];

   // link outputs
   // the bit clock output is held low whenever the pin is an input, so a late
   // enable change cannot put a stale high level on a pin the host is driving
   assign bclk_o = st_ff.bclk;
   assign bclk_oe_o = st_ff.bclk_oe;
   assign frame_sync_out_o = st_ff.frame_sync_out;
   assign sleep_o = (st_ff.pwr == PWR_SLEEP);

   // checks
   // all checks run on the reference clock and are switched off while reset is low
   // checks that look back across the reset edge are guarded by the past reset level,
   // because the edge that leaves reset still loads reset values, not the next state
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_ack_single_pulse: assert property (req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single pulse");
   a_rx_write_lands: assert property (wr_take && idx == `CGM_IDX_RX_GAIN
      |=> in_path_o.line_in_gain_sel == $past(wb_dat_i[7:6])
      && in_path_o.recursive_filter_select == $past(wb_dat_i[0]))
      else $error("receive gain write lost");
   a_vol_reserved_zero: assert property (wr_take |=> !st_ff.adc_vol[7] && !st_ff.dac_vol[7])
      else $error("volume reserved bit set");
   a_atten_upper_zero: assert property (wr_take && idx == `CGM_IDX_ATTEN
      |=> st_ff.atten[7:4] == 4'h0 && out_path_o.line_out_atten == $past(wb_dat_i[3:2]))
      else $error("attenuation write wrong");
   // the flag word trails the pins by one edge; the edge that leaves reset loads zero instead
   a_status_follows: assert property ($past(rst_n_i) |-> st_ff.status == {$past(short_flags_i), 5'h00})
      else $error("status does not track short flags");
   a_read_status: assert property (req && !wb_we_i && !wb_ack_o && idx == `CGM_IDX_STATUS
      |=> wb_dat_o == {24'h000000, $past(st_ff.status)})
      else $error("status read wrong");
   a_slave_no_drive: assert property (!master_mode_i |=> !bclk_oe_o && !bclk_o)
      else $error("bit clock driven in slave mode");
   a_sleep_quiet: assert property (sleep_o [*2] |-> !frame_sync_out_o && !bclk_o)
      else $error("link active while asleep");
   a_frame_sync_out_first_bit: assert property ($rose(frame_sync_out_o) |-> st_ff.bit_cnt == 8'h00)
      else $error("frame sync off frame start");

   // frame sync may only stand while the bit counter sits on the first bit
   a_frame_sync_out_only_start: assert property (frame_sync_out_o |-> st_ff.bit_cnt == 8'h00)
      else $error("frame sync high away from frame start");

   // write paths: each field must reach its port one edge after the write lands
   // a shifted field would slip past a readback test, so the ports are checked here
   a_adc_write_lands: assert property (wr_take && idx == `CGM_IDX_ADC_VOL
      |=> out_path_o.receive_pga_gain == $past(wb_dat_i[6:2])
      && out_path_o.line_out_enable == $past(wb_dat_i[1])
      && out_path_o.handset_out_enable == $past(wb_dat_i[0]))
      else $error("adc volume write lost");

   // transmit gain and speaker gates share the layout of the receive side
   a_dac_write_lands: assert property (wr_take && idx == `CGM_IDX_DAC_VOL
      |=> out_path_o.transmit_pga_gain == $past(wb_dat_i[6:2])
      && out_path_o.left_speaker_enable == $past(wb_dat_i[1])
      && out_path_o.right_speaker_enable == $past(wb_dat_i[0]))
      else $error("dac volume write lost");

   // mute bits and microphone gain of the input path, bits 5 down to 1 in order
   a_rx_mutes_land: assert property (wr_take && idx == `CGM_IDX_RX_GAIN
      |=> {in_path_o.line_in_silence, in_path_o.microphone_gain_sel, in_path_o.microphone_silence,
      in_path_o.handset_in_silence} == $past(wb_dat_i[5:1]))
      else $error("input path write lost");

   // speaker attenuation sits in the two lowest bits
   a_spk_atten_lands: assert property (wr_take && idx == `CGM_IDX_ATTEN
      |=> out_path_o.speaker_out_atten == $past(wb_dat_i[1:0]))
      else $error("speaker attenuation write lost");

   // a write to status or to an unmapped index must leave every control byte alone
   a_stray_write_quiet: assert property (wr_take && (idx == `CGM_IDX_STATUS || idx > `CGM_IDX_ATTEN
      || idx < `CGM_IDX_RX_GAIN)
      |=> $stable(st_ff.rx_gain) && $stable(st_ff.adc_vol) && $stable(st_ff.dac_vol) && $stable(st_ff.atten))
      else $error("stray write changed a register");

   // a write without the low byte lane selected must not land anywhere
   a_lane_gate: assert property (req && wb_we_i && !wb_sel_i[0]
      |=> $stable(st_ff.rx_gain) && $stable(st_ff.adc_vol) && $stable(st_ff.dac_vol) && $stable(st_ff.atten))
      else $error("write without lane select landed");

   // the low status bits carry nothing and must stay zero
   a_status_low_zero: assert property (st_ff.status[4:0] == 5'h00)
      else $error("status low bits not zero");

   // first edge out of reset: every register at its initial value and the device awake
   a_reset_values: assert property (!$past(rst_n_i) |-> st_ff.rx_gain == `CGM_RST_RX_GAIN
      && st_ff.adc_vol == `CGM_RST_VOL && st_ff.dac_vol == `CGM_RST_VOL
      && st_ff.status == `CGM_RST_STATUS && st_ff.atten == `CGM_RST_ATTEN
      && !sleep_o)
      else $error("register not at reset value");

   // sleep is entered one edge after the request and held until reset
   a_sleep_entry: assert property (sleep_req_i |=> sleep_o)
      else $error("sleep request ignored");
   a_sleep_holds: assert property (sleep_o |=> sleep_o)
      else $error("sleep left without reset");

   // pin direction follows the mode pin one edge later, outside the reset edge
   a_bclk_dir: assert property ($past(rst_n_i) |-> bclk_oe_o == $past(master_mode_i))
      else $error("bit clock direction wrong");

   // every ack answers a request that stood at the edge before
   a_ack_needs_req: assert property (wb_ack_o |-> $past(req))
      else $error("ack without request");

   // scenarios worth seeing: register write, status read, frame start, sleep, slave frame
   c_reg_write: cover property (wr_take && idx == `CGM_IDX_DAC_VOL);
   c_status_read: cover property (req && !wb_we_i && idx == `CGM_IDX_STATUS && short_flags_i != 3'h0);
   c_frame_start: cover property ($rose(frame_sync_out_o));
   c_sleep_enter: cover property ($rose(sleep_o));
   c_slave_frame: cover property (!master_mode_i && $rose(frame_sync_out_o));
endmodule

// ### inc/cgm_consts.svh
// register offsets, field positions, reset values and masks of the codec gain bank
`ifndef CGM_CONSTS_SVH
`define CGM_CONSTS_SVH
// register indices; byte address is four times the index
`define CGM_IDX_RX_GAIN 6'h05
`define CGM_IDX_ADC_VOL 6'h06
`define CGM_IDX_DAC_VOL 6'h07
`define CGM_IDX_STATUS 6'h08
`define CGM_IDX_ATTEN 6'h09
// reset values
`define CGM_RST_RX_GAIN 8'h47
`define CGM_RST_VOL 8'h5c
`define CGM_RST_STATUS 8'h00
`define CGM_RST_ATTEN 8'h00
// writable bits per register
`define CGM_WMASK_RX_GAIN 8'hff
`define CGM_WMASK_VOL 8'h7f
`define CGM_WMASK_ATTEN 8'h0f
// field positions
`define CGM_LIG_LSB 6
`define CGM_LIM_BIT 5
`define CGM_MCG_LSB 3
`define CGM_MCM_BIT 2
`define CGM_HIM_BIT 1
`define CGM_IIR_BIT 0
`define CGM_PGA_LSB 2
`define CGM_EN_HI_BIT 1
`define CGM_EN_LO_BIT 0
`define CGM_LOT_LSB 2
`define CGM_SOT_LSB 0
`define CGM_SHORT_LSB 5
`endif

// ### inc/cgm_pkg.sv
// types of the codec gain, mute and status register bank
package cgm_pkg;
   // power state, reset always lands in run
   typedef enum logic [0:0] {
      PWR_RUN = 1'b0,
      PWR_SLEEP = 1'b1
   } cgm_pwr_type;
   // input path controls
   typedef struct packed {
      logic [1:0] line_in_gain_sel;
      logic line_in_silence;
      logic [1:0] microphone_gain_sel;
      logic microphone_silence;
      logic handset_in_silence;
      logic recursive_filter_select;
   } cgm_in_path_type;
   // output path controls
   typedef struct packed {
      logic [4:0] receive_pga_gain;
      logic [4:0] transmit_pga_gain;
      logic line_out_enable;
      logic handset_out_enable;
      logic left_speaker_enable;
      logic right_speaker_enable;
      logic [1:0] line_out_atten;
      logic [1:0] speaker_out_atten;
   } cgm_out_path_type;
   // whole state of the bank
   typedef struct packed {
      logic [7:0] rx_gain;
      logic [7:0] adc_vol;
      logic [7:0] dac_vol;
      logic [7:0] status;
      logic [7:0] atten;
      logic ack;
      logic [7:0] rdat;
      cgm_pwr_type pwr;
      logic [7:0] div_cnt;
      logic bclk;
      logic bclk_oe;
      logic bclk_prev;
      logic [7:0] bit_cnt;
      logic frame_sync_out;
   } cgm_state_type;
endpackage

// ### tb/cgm_host_model.sv
// host-side model: supplies the bit clock while the codec runs in slave mode
`timescale 1ns/100ps
module cgm_host_model #(
   parameter int HALF = 3
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // host drives the bit clock while high
   input wire logic run_i,
   output logic bclk_o
);
   logic [3:0] cnt_ff; // ref cycles spent in this half period
   // bit clock stands low when not supplied, toggles every HALF cycles otherwise
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_ff <= 4'h0;
         bclk_o <= 1'b0;
      end
      else if (!run_i)
      begin
         cnt_ff <= 4'h0;
         bclk_o <= 1'b0;
      end
      else if (cnt_ff == 4'(HALF - 1))
      begin
         cnt_ff <= 4'h0;
         bclk_o <= ~bclk_o;
      end
      else
         cnt_ff <= cnt_ff + 4'h1;
   end
endmodule

// ### tb/cgm_regs_tb_top.sv
// self-checking bench for the codec gain and status register bank
`timescale 1ns/100ps
module cgm_regs_tb_top;
   import cgm_pkg::*;
   logic clk, rst_n, cyc, stb, we, ack, mm, slp_req, hbclk, bclk, oe, fs, slp;
   logic [7:0] adr, q;
   logic [3:0] sel;
   logic [31:0] dat_i, dat_o;
   logic [2:0] flags;
   cgm_in_path_type inp;
   cgm_out_path_type outp;
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;
   // reset values, written values and expected readback per register
   logic [7:0] rv [5] = '{8'h47, 8'h5c, 8'h5c, 8'h00, 8'h00};
   logic [7:0] wv [5] = '{8'ha6, 8'hf9, 8'h86, 8'hff, 8'hf6};
   logic [7:0] ev [5] = '{8'ha6, 8'h79, 8'h06, 8'ha0, 8'h06};
   cgm_regs #(.BCLK_DIV(2), .FRAME_BITS(8)) uut (.ref_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .short_flags_i(flags), .in_path_o(inp), .out_path_o(outp), .master_mode_i(mm),
      .sleep_req_i(slp_req), .bclk_i(hbclk), .bclk_o(bclk), .bclk_oe_o(oe), .frame_sync_out_o(fs),
      .sleep_o(slp));
   cgm_host_model #(.HALF(3)) host (.ref_clk_i(clk), .rst_n_i(rst_n), .run_i(~mm), .bclk_o(hbclk));
   // 25 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // cut a hang short
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         final_report();
      end
   end
   // print counts and verdict, then stop
   task final_report();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // compare one value
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // hold reset low for 20 cycles
   task do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   // one classic wishbone cycle, held until ack
   task wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic s0, output logic [7:0] r);
      @(posedge clk);
      {cyc, stb, we, adr, dat_i, sel} <= {2'b11, w, a, 24'h0, d, 3'b0, s0};
      // look at ack mid-cycle, away from the edge that launches it
      do @(negedge clk); while (ack !== 1'b1);
      r = dat_o[7:0];
      // the next rising edge samples ack high and lands the write; release only then
      @(posedge clk);
      {cyc, stb} <= 2'b00;
   endtask
   // cycles from one frame sync rise to the next
   task frame_gap(input int exp);
      int n;
      n = 0;
      while (fs !== 1'b0) @(negedge clk);
      while (fs !== 1'b1) @(negedge clk);
      do begin @(negedge clk); n++; end while (fs !== 1'b0);
      do begin @(negedge clk); n++; end while (fs !== 1'b1);
      chk(n, exp);
      @(posedge clk);
   endtask
   // main sequence
   initial
   begin
      {rst_n, cyc, stb, we, adr, sel, dat_i, flags, mm, slp_req} = '0;
      mm = 1'b1;
      do_reset();
      for (int i = 0; i < 5; i++)
      begin
         wb(1'b0, 8'h14 + 8'(4 * i), 8'h00, 1'b1, q);
         chk(q, rv[i]);
      end
      wb(1'b1, 8'h14, 8'h00, 1'b0, q);
      wb(1'b0, 8'h14, 8'h00, 1'b1, q);
      chk(q, 8'h47);
      flags <= 3'b101;
      for (int i = 0; i < 5; i++)
         wb(1'b1, 8'h14 + 8'(4 * i), wv[i], 1'b1, q);
      for (int i = 0; i < 5; i++)
      begin
         wb(1'b0, 8'h14 + 8'(4 * i), 8'h00, 1'b1, q);
         chk(q, ev[i]);
      end
      chk(inp, 8'ha6);
      chk(outp, {5'b11110, 5'b00001, 4'b0110, 2'b01, 2'b10});
      flags <= 3'b010;
      wb(1'b0, 8'h20, 8'h00, 1'b1, q);
      chk(q, 8'h40);
      wb(1'b0, 8'h28, 8'h00, 1'b1, q);
      chk(q, 8'h00);
      frame_gap(32);
      chk(oe, 1'b1);
      mm <= 1'b0;
      repeat (8) @(posedge clk);
      frame_gap(48);
      chk(oe, 1'b0);
      chk(bclk, 1'b0);
      slp_req <= 1'b1;
      repeat (60) @(posedge clk);
      chk({slp, fs}, 2'b10);
      slp_req <= 1'b0;
      do_reset();
      @(posedge clk);
      chk(slp, 1'b0);
      wb(1'b0, 8'h18, 8'h00, 1'b1, q);
      chk(q, 8'h5c);
      final_report();
   end
endmodule
